/* design/parity_check_pkg.sv */
/*
 * Package for the program memory parity checker: register map, field
 * positions, reset values, mode encoding and the access carrier.
 * Assumes a single 20 MHz core clock and a synchronous active-high reset.
 */
package parity_check_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [31:0] STATUS_ADDR   = 32'h0184_6404;
    localparam logic [31:0] COMMAND_ADDR  = 32'h0184_6408;
    localparam logic [31:0] LOCATION_ADDR = 32'h0184_640C;

    // ------------------------------------------------------------
    // status and command bit positions
    // ------------------------------------------------------------
    localparam int BIT_ON        = 0;
    localparam int BIT_OFF       = 2;
    localparam int BIT_HOLD      = 3;
    localparam int BIT_FETCH_ERR = 5;
    localparam int BIT_XFER_ERR  = 6;

    // location register fields
    localparam int LOC_ADDR_LSB  = 5;
    localparam int LOC_RAM_BIT   = 0;

    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int WORD_BITS  = 256;
    localparam int INDEX_BITS = 6;
    localparam int DEPTH      = 64;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // checker mode, gray coded along off -> on -> hold
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_ON   = 2'h1,
        MODE_HOLD = 2'h3
    } mode_e;

    localparam mode_e RESET_MODE = MODE_OFF;

    // one memory access seen by the checker
    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic                   full;     // 256 bits wide and aligned
        logic                   fetch;    // program fetch, else dma/internal_transfer_engine
        logic                   ram;      // ram portion, else cache
        logic [31:0]            addr;
        logic [WORD_BITS-1:0]   data;
    } access_s;

endpackage : parity_check_pkg

/* design/parity_store.sv */
/*
 * Parity store: one parity bit and one valid bit per 256-bit word.
 * Read data come out of a register one cycle after the read index.
 * Assumes the caller never reads and writes the same entry with
 * expectations of write-through.
 */
`timescale 1ns/100ps

module parity_store (
    // clock and reset
    input  wire logic                                   mclk_i,
    input  wire logic                                   reset_i,
    // write port
    input  wire logic                                   wr_en_i,
    input  wire logic [parity_check_pkg::INDEX_BITS-1:0] wr_idx_i,
    input  wire logic                                   wr_par_i,
    input  wire logic                                   wr_vld_i,
    // read port
    input  wire logic [parity_check_pkg::INDEX_BITS-1:0] rd_idx_i,
    output logic                                        rd_par_o,
    output logic                                        rd_vld_o
);

    logic [parity_check_pkg::DEPTH-1:0] par_r;
    logic [parity_check_pkg::DEPTH-1:0] vld_r;

    // valid bits are cleared at reset; parity bits need no reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            vld_r <= '0;
        end else if (wr_en_i) begin
            vld_r[wr_idx_i] <= wr_vld_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wr_en_i) begin
            par_r[wr_idx_i] <= wr_par_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_par_o <= 1'b0;
            rd_vld_o <= 1'b0;
        end else begin
            rd_par_o <= par_r[rd_idx_i];
            rd_vld_o <= vld_r[rd_idx_i];
        end
    end

endmodule : parity_store

/* design/program_memory_parity_checker.sv */
/*
 * Program memory parity checker: watches writes and 256-bit reads of the
 * level-one program memory, keeps parity per word, reports fetch and
 * transfer errors, and holds status, command and location registers.
 * Assumes accesses arrive one per cycle on acc_i from same-clock logic.
 */
// Contract
// [R1] parity is xor of all 256 bits
// [R2] every enabled or disabled write stores parity and valid bit
// [R3] narrow transfer writes mark parity invalid
// [R4] check full aligned reads, ram and cache
// [R5] fetch error drives cpu exception output
// [R6] transfer error drives interrupt controller output
// [R7] command register changes mode, status reports it
// [R8] enabled: writes update, reads checked
// [R9] disabled: writes clear valid, no checks
// [R10] suspended: writes keep store, no checks
// [R11] transfer error sets bit 6, records address
// [R12] fetch error sets bit 5, records address
// [R13] exactly one mode flag is set
// [R14] at most one error flag set
// [R15] status writes change nothing
// [R16] reset leaves checker disabled
// [R17] command ones act; several mode bits disable
// [R18] location holds bits 31-5 plus ram flag
// [R19] first error kept; fetch replaces transfer error
// [R20] error only when valid and parity differs
// [R21] reserved status bits read zero
`timescale 1ns/100ps

module program_memory_parity_checker (
    // clock and reset
    input  wire logic                             mclk_i,
    input  wire logic                             reset_i,
    // memory access observed
    input  wire parity_check_pkg::access_s        acc_i,
    // register port
    input  wire logic [31:0]                      reg_addr_i,
    input  wire logic [31:0]                      reg_wdata_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    output logic [31:0]                           reg_rdata_o,
    // error outputs
    output logic                                  fetch_exception_o,
    output logic                                  transfer_error_o
);

    localparam int IB = parity_check_pkg::INDEX_BITS;
    localparam int AL = parity_check_pkg::LOC_ADDR_LSB;

    // ------------------------------------------------------------
    // write path into the parity store
    // ------------------------------------------------------------
    parity_check_pkg::mode_e mode_r;
    logic                    wr_en;
    logic                    wr_vld;
    logic                    acc_par;
    logic [IB-1:0]           acc_idx;

    assign acc_par = ^acc_i.data;                          // see [R1]
    assign acc_idx = acc_i.addr[AL +: IB];

    // enabled writes store parity, narrow ones invalid; disabled clears
    always_comb begin
        wr_en  = 1'b0;
        wr_vld = 1'b0;
        if (acc_i.valid && acc_i.write) begin
            case (mode_r)
                parity_check_pkg::MODE_ON: begin
                    wr_en  = 1'b1;                         // see [R2] [R8]
                    wr_vld = acc_i.full;                   // see [R3]
                end
                parity_check_pkg::MODE_OFF: begin
                    wr_en  = 1'b1;                         // see [R9]
                    wr_vld = 1'b0;
                end
                parity_check_pkg::MODE_HOLD: begin
                    wr_en  = 1'b0;                         // see [R10]
                end
                default: begin
                    wr_en  = 1'b0;
                end
            endcase
        end
    end

    logic st_par;
    logic st_vld;

    parity_store store_u (
        .mclk_i   (mclk_i),
        .reset_i  (reset_i),
        .wr_en_i  (wr_en),
        .wr_idx_i (acc_idx),
        .wr_par_i (acc_par),
        .wr_vld_i (wr_vld),
        .rd_idx_i (acc_idx),
        .rd_par_o (st_par),
        .rd_vld_o (st_vld)
    );

    // ------------------------------------------------------------
    // read check, one stage behind the store lookup
    // ------------------------------------------------------------
    logic        chk_r;
    logic        chk_par_r;
    logic        chk_fetch_r;
    logic        chk_ram_r;
    logic [26:0] chk_addr_r;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            chk_r       <= 1'b0;
            chk_par_r   <= 1'b0;
            chk_fetch_r <= 1'b0;
            chk_ram_r   <= 1'b0;
            chk_addr_r  <= 27'h0000000;
        end else begin
            chk_r       <= acc_i.valid && !acc_i.write && acc_i.full
                           && mode_r == parity_check_pkg::MODE_ON; // see [R4]
            chk_par_r   <= acc_par;
            chk_fetch_r <= acc_i.fetch;
            chk_ram_r   <= acc_i.ram;
            chk_addr_r  <= acc_i.addr[31:AL];
        end
    end

    logic bad;
    assign bad = chk_r && st_vld && (st_par != chk_par_r);  // see [R20]

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic cmd_wr;
    logic [2:0] mode_bits;
    logic fetch_clr;
    logic xfer_clr;

    assign cmd_wr = reg_wr_i
                    && reg_addr_i == parity_check_pkg::COMMAND_ADDR; // see [R7]
    assign mode_bits = {reg_wdata_i[parity_check_pkg::BIT_HOLD],
                        reg_wdata_i[parity_check_pkg::BIT_OFF],
                        reg_wdata_i[parity_check_pkg::BIT_ON]};
    assign fetch_clr = cmd_wr && reg_wdata_i[parity_check_pkg::BIT_FETCH_ERR];
    assign xfer_clr  = cmd_wr && reg_wdata_i[parity_check_pkg::BIT_XFER_ERR];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mode_r <= parity_check_pkg::RESET_MODE;          // see [R16]
        end else if (cmd_wr) begin
            case (mode_bits)                                 // see [R17]
                3'h0: mode_r <= mode_r;
                3'h1: mode_r <= parity_check_pkg::MODE_ON;
                3'h2: mode_r <= parity_check_pkg::MODE_OFF;
                3'h4: mode_r <= parity_check_pkg::MODE_HOLD;
                default: mode_r <= parity_check_pkg::MODE_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // error recording
    // ------------------------------------------------------------
    logic        fetch_err_r;
    logic        xfer_err_r;
    logic [26:0] loc_addr_r;
    logic        loc_ram_r;
    logic        take_fetch;
    logic        take_xfer;

    // a fetch error is taken unless a fetch error is already held
    // (and not being cleared); a transfer error only when nothing is held
    assign take_fetch = bad && chk_fetch_r
                        && (!fetch_err_r || fetch_clr);      // see [R19]
    assign take_xfer  = bad && !chk_fetch_r
                        && (!fetch_err_r || fetch_clr)
                        && (!xfer_err_r || xfer_clr);        // see [R19]

    // set wins over clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fetch_err_r <= 1'b0;
            xfer_err_r  <= 1'b0;
        end else if (take_fetch) begin
            fetch_err_r <= 1'b1;                             // see [R12]
            xfer_err_r  <= 1'b0;                             // see [R14]
        end else if (take_xfer) begin
            fetch_err_r <= 1'b0;
            xfer_err_r  <= 1'b1;                             // see [R11]
        end else begin
            if (fetch_clr) fetch_err_r <= 1'b0;
            if (xfer_clr)  xfer_err_r  <= 1'b0;
        end
    end

    // location keeps the address of the recorded error
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            loc_addr_r <= 27'h0000000;
            loc_ram_r  <= 1'b0;
        end else if (take_fetch || take_xfer) begin
            loc_addr_r <= chk_addr_r;                        // see [R18]
            loc_ram_r  <= chk_ram_r;
        end
    end

    // exception lines pulse for one cycle on each recorded error
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fetch_exception_o <= 1'b0;
            transfer_error_o  <= 1'b0;
        end else begin
            fetch_exception_o <= take_fetch;                 // see [R5]
            transfer_error_o  <= take_xfer;                  // see [R6]
        end
    end

    // ------------------------------------------------------------
    // register read; status writes are simply not decoded
    // ------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] loc_word;

    always_comb begin
        status_word = parity_check_pkg::READ_ZERO;           // see [R21]
        status_word[parity_check_pkg::BIT_ON] =
            (mode_r == parity_check_pkg::MODE_ON);           // see [R13]
        status_word[parity_check_pkg::BIT_OFF] =
            (mode_r == parity_check_pkg::MODE_OFF);
        status_word[parity_check_pkg::BIT_HOLD] =
            (mode_r == parity_check_pkg::MODE_HOLD);
        status_word[parity_check_pkg::BIT_FETCH_ERR] = fetch_err_r;
        status_word[parity_check_pkg::BIT_XFER_ERR]  = xfer_err_r;
        loc_word = parity_check_pkg::READ_ZERO;
        loc_word[31:AL] = loc_addr_r;
        loc_word[parity_check_pkg::LOC_RAM_BIT] = loc_ram_r;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            reg_rdata_o <= parity_check_pkg::READ_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)                                // see [R15]
                parity_check_pkg::STATUS_ADDR:   reg_rdata_o <= status_word;
                parity_check_pkg::LOCATION_ADDR: reg_rdata_o <= loc_word;
                default: reg_rdata_o <= parity_check_pkg::READ_ZERO;
            endcase
        end else begin
            reg_rdata_o <= parity_check_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    one_mode_a: assert property ( // see [R13]
        @(posedge mclk_i) disable iff (reset_i)
        $onehot({status_word[0], status_word[2], status_word[3]}))
        else $error("mode flags not one-hot");
    one_error_a: assert property ( // see [R14]
        @(posedge mclk_i) disable iff (reset_i)
        !(fetch_err_r && xfer_err_r))
        else $error("both error flags set");
    reserved_zero_a: assert property ( // see [R21]
        @(posedge mclk_i) disable iff (reset_i)
        (status_word & 32'hFFFF_FF92) == 32'h0000_0000)
        else $error("reserved status bit set");
    fetch_exc_a: assert property ( // see [R5]
        @(posedge mclk_i) disable iff (reset_i)
        bad && chk_fetch_r && !fetch_err_r
        |=> fetch_exception_o && fetch_err_r)
        else $error("fetch error not raised");
    xfer_irq_a: assert property ( // see [R6]
        @(posedge mclk_i) disable iff (reset_i)
        transfer_error_o |-> xfer_err_r && !fetch_exception_o)
        else $error("transfer error without flag");
    no_check_off_a: assert property ( // see [R9]
        @(posedge mclk_i) disable iff (reset_i)
        mode_r != parity_check_pkg::MODE_ON |=> !chk_r)
        else $error("read checked while not enabled");
    hold_store_a: assert property ( // see [R10]
        @(posedge mclk_i) disable iff (reset_i)
        mode_r == parity_check_pkg::MODE_HOLD |-> !wr_en)
        else $error("store written while suspended");
    multi_mode_a: assert property ( // see [R17]
        @(posedge mclk_i) disable iff (reset_i)
        cmd_wr && !$onehot0(mode_bits)
        |=> mode_r == parity_check_pkg::MODE_OFF)
        else $error("multi mode write not disabling");
    first_kept_a: assert property ( // see [R19]
        @(posedge mclk_i) disable iff (reset_i)
        xfer_err_r && !xfer_clr && !take_fetch |=> $stable(loc_addr_r))
        else $error("recorded address overwritten");
    reset_off_a: assert property ( // see [R16]
        @(posedge mclk_i)
        $fell(reset_i) |-> mode_r == parity_check_pkg::MODE_OFF)
        else $error("not disabled after reset");
    // a write anywhere but the command register must leave the mode alone
    status_ro_a: assert property ( // see [R15]
        @(posedge mclk_i) disable iff (reset_i)
        reg_wr_i && reg_addr_i != parity_check_pkg::COMMAND_ADDR
        |=> mode_r == $past(mode_r))
        else $error("mode changed without command");
    off_clear_a: assert property ( // see [R9]
        @(posedge mclk_i) disable iff (reset_i)
        acc_i.valid && acc_i.write && mode_r == parity_check_pkg::MODE_OFF
        |-> wr_en && !wr_vld)
        else $error("disabled write kept valid bit");
    error_loc_a: assert property ( // see [R18]
        @(posedge mclk_i) disable iff (reset_i)
        take_fetch || take_xfer
        |=> loc_addr_r == $past(chk_addr_r) && loc_ram_r == $past(chk_ram_r))
        else $error("location not taken from failing read");

    fetch_err_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        fetch_exception_o);
    xfer_err_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        transfer_error_o);
    replace_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        xfer_err_r ##1 fetch_err_r);
    hold_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        mode_r == parity_check_pkg::MODE_HOLD && wr_en == 1'b0
        && acc_i.valid && acc_i.write);

endmodule : program_memory_parity_checker

/* tb/access_model.sv */
/*
 * Access source model: stands in for the cpu fetch unit and the dma
 * engines in front of the program memory, with a mirror of its words.
 * Assumes one request per go_i pulse from the bench, on the same clock.
 */
`timescale 1ns/100ps

module access_model #(
    parameter logic [20:0] BASE = 21'h0001C
) (
    // clock
    input  wire logic                       mclk_i,
    // request from the bench
    input  wire logic                       go_i,
    input  wire logic [1:0]                 op_i,
    input  wire logic [5:0]                 idx_i,
    input  wire logic                       ram_i,
    input  wire logic                       flip_i,
    input  wire logic [255:0]               data_i,
    // access towards the checker
    output parity_check_pkg::access_s       acc_o
);
    // op: 0 full write, 1 narrow write, 2 fetch read, 3 transfer read
    logic [255:0] mem [64];

    initial acc_o = '0;

    always @(posedge mclk_i) begin
        acc_o.valid <= go_i;
        acc_o.write <= go_i && !op_i[1];
        acc_o.full  <= go_i && (op_i != 2'h1); // fetches full
        acc_o.fetch <= go_i && (op_i == 2'h2);
        acc_o.ram   <= ram_i;
        acc_o.addr  <= {BASE, idx_i, 5'h00};
        if (go_i) begin
            if (op_i == 2'h0) begin
                mem[idx_i]   <= data_i;
                acc_o.data   <= data_i;
            end else if (op_i == 2'h1) begin
                mem[idx_i][31:0] <= data_i[31:0];
                acc_o.data   <= data_i;
            end else begin
                // flip_i corrupts one bit, as a memory upset would
                acc_o.data <= mem[idx_i] ^ {255'h0, flip_i};
            end
        end else begin
            // idle bus keeps moving so no stale word looks valid
            acc_o.data <= ~acc_o.data;
        end
    end
endmodule : access_model

/* tb/program_memory_parity_checker_tb.sv */
/*
 * Self-checking bench for the program memory parity checker.
 * Assumes the design package is compiled first; access_model drives the
 * memory side, the bench drives the register port.
 */
`timescale 1ns/100ps

module program_memory_parity_checker_tb;
    localparam logic [20:0] BASE = 21'h0001C;
    localparam logic [31:0] STA  = parity_check_pkg::STATUS_ADDR;
    localparam logic [31:0] CMD  = parity_check_pkg::COMMAND_ADDR;
    localparam logic [31:0] LOC  = parity_check_pkg::LOCATION_ADDR;

    logic                       mclk_i = 1'b0;
    logic                       reset_i = 1'b1;
    parity_check_pkg::access_s  acc;
    logic                       go = 1'b0;
    logic [1:0]                 op = 2'h0;
    logic [5:0]                 idx = 6'h00;
    logic                       ram = 1'b0;
    logic                       flip = 1'b0;
    logic [255:0]               data = '0;
    logic [31:0]                reg_addr = 32'h0;
    logic [31:0]                reg_wdata = 32'h0;
    logic                       reg_wr = 1'b0;
    logic                       reg_rd = 1'b0;
    logic [31:0]                rdata;
    logic                       fexc;
    logic                       xerr;
    logic [31:0]                fcnt = 32'h0;
    logic [31:0]                xcnt = 32'h0;
    logic [31:0]                ef = 32'h0;
    logic [31:0]                ex = 32'h0;
    int                         bad_count = 0;
    int                         total_checks = 0;
    int                         seed = 32'hA3FD;
    int                         i;

    access_model #(.BASE(BASE)) u_access_model (.mclk_i(mclk_i),
        .go_i(go), .op_i(op), .idx_i(idx), .ram_i(ram), .flip_i(flip),
        .data_i(data), .acc_o(acc));

    program_memory_parity_checker u_program_memory_parity_checker (
        .mclk_i(mclk_i), .reset_i(reset_i), .acc_i(acc),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .fetch_exception_o(fexc), .transfer_error_o(xerr));

    always #25 mclk_i = ~mclk_i;

    // pulses are counted, so a stretched pulse shows as an extra count
    always @(posedge mclk_i) begin
        fcnt <= fcnt + {31'h0, fexc};
        xcnt <= xcnt + {31'h0, xerr};
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish();
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task reg_w(input logic [31:0] a, d);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask : reg_w

    task reg_r(input logic [31:0] a, input logic [31:0] e, input string n);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        #1;
        check(n, rdata, e);
    endtask : reg_r

    task mem_op(input logic [1:0] o, input logic [5:0] x, input logic r, f,
                input logic [255:0] d);
        @(posedge mclk_i);
        go <= 1'b1;
        op <= o;
        idx <= x;
        ram <= r;
        flip <= f;
        data <= d;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (4) @(posedge mclk_i);
        #1;
        check("fetch pulses", fcnt, ef);
        check("transfer pulses", xcnt, ex);
    endtask : mem_op

    function automatic logic [255:0] rnd();
        logic [255:0] r;
        r = '0;
        for (int k = 0; k < 8; k++) r = {r[223:0], 32'($random(seed))};
        return r;
    endfunction : rnd

    function automatic logic [31:0] loc(input logic [5:0] x, input logic r);
        return {BASE, x, 4'h0, r};
    endfunction : loc

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #(50 * 20000);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic [255:0] d;
        logic [5:0]   x;
        logic         f;
        logic         p;
        d = rnd();
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        reg_r(STA, 32'h4, "status at reset");
        reg_r(LOC, 32'h0, "location at reset");
        reg_r(CMD, 32'h0, "command readback");
        reg_r(32'h0184_6400, 32'h0, "unmapped read");
        reg_w(STA, 32'hFFFF_FFFF);
        reg_r(STA, 32'h4, "status after write");
        // single and clashing mode requests
        reg_w(CMD, 32'h1);
        reg_r(STA, 32'h1, "enable");
        reg_w(CMD, 32'h8);
        reg_r(STA, 32'h8, "suspend");
        reg_w(CMD, 32'h5);
        reg_r(STA, 32'h4, "two mode bits");
        reg_w(CMD, 32'h1);
        reg_w(CMD, 32'hD);
        reg_r(STA, 32'h4, "three mode bits");
        // disabled: no checks, writes clear valid
        reg_w(CMD, 32'h1);
        mem_op(2'h0, 6'h01, 1'b1, 1'b0, d);
        mem_op(2'h0, 6'h02, 1'b1, 1'b0, d);
        reg_w(CMD, 32'h4);
        mem_op(2'h2, 6'h02, 1'b1, 1'b1, d);
        mem_op(2'h0, 6'h01, 1'b1, 1'b0, ~d);
        reg_w(CMD, 32'h1);
        mem_op(2'h2, 6'h01, 1'b1, 1'b1, d);
        // fetch error, then a transfer error is dropped
        ef = 32'h1;
        mem_op(2'h2, 6'h02, 1'b1, 1'b1, d);
        reg_r(STA, 32'h21, "fetch flag");
        reg_r(LOC, loc(6'h02, 1'b1), "fetch location");
        mem_op(2'h3, 6'h02, 1'b1, 1'b1, d);
        reg_r(STA, 32'h21, "second error dropped");
        reg_w(CMD, 32'h20);
        reg_r(STA, 32'h1, "fetch clear");
        // transfer error replaced by a later fetch error
        ex = 32'h1;
        mem_op(2'h3, 6'h02, 1'b1, 1'b1, d);
        reg_r(STA, 32'h41, "transfer flag");
        reg_r(LOC, loc(6'h02, 1'b1), "transfer location");
        mem_op(2'h0, 6'h03, 1'b0, 1'b0, d);
        ef = 32'h2;
        mem_op(2'h2, 6'h03, 1'b0, 1'b1, d);
        reg_r(STA, 32'h21, "fetch replaces");
        reg_r(LOC, loc(6'h03, 1'b0), "cache location");
        reg_w(CMD, 32'h61);
        reg_r(STA, 32'h1, "clear both");
        // narrow write leaves the word unchecked
        mem_op(2'h1, 6'h03, 1'b1, 1'b0, ~d);
        mem_op(2'h3, 6'h03, 1'b1, 1'b1, d);
        // suspend keeps old parity while the word changes
        mem_op(2'h0, 6'h04, 1'b1, 1'b0, d);
        reg_w(CMD, 32'h8);
        mem_op(2'h0, 6'h04, 1'b1, 1'b0, d ^ 256'h1);
        reg_w(CMD, 32'h1);
        ef = 32'h3;
        mem_op(2'h2, 6'h04, 1'b1, 1'b0, d);
        reg_w(CMD, 32'h20);
        // random words, random corruption and requester
        for (i = 0; i < 16; i++) begin
            x = {1'b1, 5'($random(seed))};
            f = 1'($random(seed));
            p = 1'($random(seed));
            mem_op(2'h0, x, 1'b1, 1'b0, rnd());
            ef = ef + {31'h0, f & p};
            ex = ex + {31'h0, f & ~p};
            mem_op(p ? 2'h2 : 2'h3, x, p, f, d);
            reg_w(CMD, 32'h60);
            reg_r(STA, 32'h1, "random clear");
        end
        tally_and_finish();
    end
endmodule : program_memory_parity_checker_tb
